// File: aex_defines.vh
// constants for the alu and branch execution block
`ifndef AEX_DEFINES_VH
`define AEX_DEFINES_VH
// operation codes (op_sel)
`define AEX_OP_W            6
`define AEX_OP_NOP          6'h00
`define AEX_OP_ADD          6'h01
`define AEX_OP_ADC          6'h02
`define AEX_OP_SUB          6'h03
`define AEX_OP_SBC          6'h04
`define AEX_OP_AND          6'h05
`define AEX_OP_OR           6'h06
`define AEX_OP_EOR          6'h07
`define AEX_OP_SETM         6'h08
`define AEX_OP_CLRM         6'h09
`define AEX_OP_TEST         6'h0a
`define AEX_OP_COM          6'h0b
`define AEX_OP_NEG          6'h0c
`define AEX_OP_INC          6'h0d
`define AEX_OP_DEC          6'h0e
`define AEX_OP_CMP          6'h0f
`define AEX_OP_CMPC         6'h10
`define AEX_OP_WADD         6'h11
`define AEX_OP_WSUB         6'h12
`define AEX_OP_MUL          6'h13
`define AEX_OP_ZJMP         6'h14
`define AEX_OP_XJMP         6'h15
`define AEX_OP_ZCALL        6'h16
`define AEX_OP_XCALL        6'h17
`define AEX_OP_CPSKIP       6'h18
`define AEX_OP_RBSKIP       6'h19
`define AEX_OP_IOSKIP       6'h1a
`define AEX_OP_BRANCH       6'h1b
`define AEX_OP_BRSGE        6'h1c
`define AEX_OP_BRSLT        6'h1d
// status flag bit positions
`define AEX_F_C             0
`define AEX_F_Z             1
`define AEX_F_N             2
`define AEX_F_V             3
`define AEX_F_S             4
`define AEX_F_H             5
`define AEX_F_T             6
`define AEX_F_I             7
// multiply mode (mul_mode): bit0 rd signed, bit1 rr signed, bit2 fractional
`define AEX_MM_SD           0
`define AEX_MM_SR           1
`define AEX_MM_FR           2
// cycle counts
`define AEX_CYC_ONE         3'h1
`define AEX_CYC_TWO         3'h2
`define AEX_CYC_THREE       3'h3
`define AEX_CYC_FOUR        3'h4
`define AEX_PC_W            22
`define AEX_RESET_PC        22'h000000
`endif

// File: aex_alu8.v
// 8-bit arithmetic and logic unit with flag generation
`timescale 1ns/1ps
`include "aex_defines.vh"
module aex_alu8 (
   op_sel,
   rd_val,
   rr_val,
   flags_in,
   res_out,
   flags_out,
   wr_en
);
   input  wire [5:0] op_sel;
   input  wire [7:0] rd_val;
   input  wire [7:0] rr_val;
   input  wire [7:0] flags_in;
   output reg  [7:0] res_out;
   output reg  [7:0] flags_out;
   output reg        wr_en;

   reg [8:0] sum;
   reg       cin;

   // flags after an add or subtract of a and b giving r
   function [5:0] arith_flags;
      input [7:0] a;
      input [7:0] b;
      input [7:0] r;
      input       sub;
      input       cout;
      reg         h;
      reg         v;
      begin
         if (sub) begin
            h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
            v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
         end else begin
            h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
            v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
         end
         // order h s v n z c
         arith_flags = {h, r[7] ^ v, v, r[7], r == 8'h00, cout};
      end
   endfunction

   always @* begin
      res_out   = rd_val;
      flags_out = flags_in;
      wr_en     = 1'b1;
      cin       = 1'b0;
      sum       = 9'h000;
      case (op_sel)
         `AEX_OP_ADD, `AEX_OP_ADC: begin
            cin = (op_sel == `AEX_OP_ADC) ? flags_in[`AEX_F_C] : 1'b0;
            sum = {1'b0, rd_val} + {1'b0, rr_val} + {8'h00, cin};
            res_out = sum[7:0];
            flags_out[5:0] = arith_flags(rd_val, rr_val, sum[7:0], 1'b0, sum[8]);
         end
         `AEX_OP_SUB, `AEX_OP_SBC, `AEX_OP_CMP, `AEX_OP_CMPC: begin
            cin = (op_sel == `AEX_OP_SBC || op_sel == `AEX_OP_CMPC) ? flags_in[`AEX_F_C] : 1'b0;
            sum = {1'b0, rd_val} - {1'b0, rr_val} - {8'h00, cin};
            res_out = sum[7:0];
            flags_out[5:0] = arith_flags(rd_val, rr_val, sum[7:0], 1'b1, sum[8]);
            // with-carry forms keep zero only if it was already set
            if (cin || op_sel == `AEX_OP_SBC || op_sel == `AEX_OP_CMPC)
               flags_out[`AEX_F_Z] = (sum[7:0] == 8'h00) & flags_in[`AEX_F_Z];
            wr_en = (op_sel == `AEX_OP_SUB || op_sel == `AEX_OP_SBC);
         end
         `AEX_OP_AND, `AEX_OP_OR, `AEX_OP_EOR, `AEX_OP_SETM, `AEX_OP_CLRM, `AEX_OP_TEST: begin
            case (op_sel)
               `AEX_OP_AND:  res_out = rd_val & rr_val;
               `AEX_OP_OR:   res_out = rd_val | rr_val;
               `AEX_OP_EOR:  res_out = rd_val ^ rr_val;
               `AEX_OP_SETM: res_out = rd_val | rr_val;
               `AEX_OP_CLRM: res_out = rd_val & ~rr_val;
               default:      res_out = rd_val & rd_val;
            endcase
            flags_out[`AEX_F_Z] = (res_out == 8'h00);
            flags_out[`AEX_F_N] = res_out[7];
            flags_out[`AEX_F_V] = 1'b0;
            flags_out[`AEX_F_S] = res_out[7];
         end
         `AEX_OP_COM: begin
            res_out = 8'hff - rd_val;
            flags_out[`AEX_F_C] = 1'b1;
            flags_out[`AEX_F_Z] = (res_out == 8'h00);
            flags_out[`AEX_F_N] = res_out[7];
            flags_out[`AEX_F_V] = 1'b0;
            flags_out[`AEX_F_S] = res_out[7];
         end
         `AEX_OP_NEG: begin
            sum = 9'h000 - {1'b0, rd_val};
            res_out = sum[7:0];
            flags_out[5:0] = arith_flags(8'h00, rd_val, sum[7:0], 1'b1, rd_val != 8'h00);
         end
         `AEX_OP_INC, `AEX_OP_DEC: begin
            res_out = (op_sel == `AEX_OP_INC) ? rd_val + 8'h01 : rd_val - 8'h01;
            flags_out[`AEX_F_Z] = (res_out == 8'h00);
            flags_out[`AEX_F_N] = res_out[7];
            flags_out[`AEX_F_V] = (op_sel == `AEX_OP_INC) ? (res_out == 8'h80) : (res_out == 8'h7f);
            flags_out[`AEX_F_S] = res_out[7] ^ flags_out[`AEX_F_V];
         end
         default: begin
            wr_en = 1'b0;
         end
      endcase
   end
endmodule

// File: aex_mul8.v
// 8x8 multiplier with signed, mixed and fractional modes
`timescale 1ns/1ps
`include "aex_defines.vh"
module aex_mul8 (
   rd_val,
   rr_val,
   mul_mode,
   prod_out,
   carry_out,
   zero_out
);
   input  wire [7:0]  rd_val;
   input  wire [7:0]  rr_val;
   input  wire [2:0]  mul_mode;
   output wire [15:0] prod_out;
   output wire        carry_out;
   output wire        zero_out;

   wire [17:0] a_ext;
   wire [17:0] b_ext;
   wire [17:0] full;
   wire [15:0] raw;

   assign a_ext = {{10{mul_mode[`AEX_MM_SD] & rd_val[7]}}, rd_val};
   assign b_ext = {{10{mul_mode[`AEX_MM_SR] & rr_val[7]}}, rr_val};
   assign full  = a_ext * b_ext;
   assign raw   = full[15:0];
   // carry is product bit 15 before the fractional shift
   assign carry_out = raw[15];
   assign prod_out  = mul_mode[`AEX_MM_FR] ? {raw[14:0], 1'b0} : raw;
   assign zero_out  = (prod_out == 16'h0000);
endmodule

// File: aex_exec.v
// execution unit for arithmetic, multiply, jump, call, skip and branch operations
// Functional notes
// - subtract immediate with carry writes result, updates six flags, one cycle
// - word add immediate on a pair, updates z c n v s, two cycles
// - word subtract immediate on a pair, updates z c n v s, two cycles
// - and, or, xor update z n v s only, one cycle
// - set-bits ors mask, clear-bits ands inverted mask, one cycle
// - zero-minus test ands register with itself, writes the result back and updates z n v s
// - multiplies write product to r1:r0, update z and c, two cycles
// - fractional multiplies shift product left once, two cycles
// - indirect jump: pc low from z, upper bits cleared, two cycles
// - extended indirect jump: upper pc bits from segment register, two cycles
// - indirect call loads z, three or four cycles by pc width
// - extended indirect call uses segment and z, four cycles
// - compare-skip-equal skips next instruction when equal, flags unchanged
// - register bit skips test a working register bit clear or set
// - io bit skips test an io register bit against required value
// - flag branch loads pc plus offset plus one, two cycles taken
// - signed ge branches on n xor v zero, lt on one
// - same-or-higher branches on carry clear, lower on carry set
// - interrupt-state branches test the global interrupt flag
// - compares update six flags and write no register
`timescale 1ns/1ps
`include "aex_defines.vh"
module aex_exec #(
   parameter WIDE_PC = 1'b1
) (
   ref_clk,
   rstn,
   clk_en,
   issue,
   op_sel,
   rd_val,
   rr_val,
   pair_val,
   imm_val,
   mul_mode,
   bit_sel,
   bit_pol,
   io_val,
   z_ptr,
   seg_val,
   flags_in,
   rel_off,
   next_two_word,
   pc_in,
   busy,
   done,
   res_we,
   res_data,
   pair_we,
   pair_data,
   prod_we,
   prod_data,
   flags_we,
   flags_out,
   pc_we,
   pc_out,
   push_pc,
   cycles
);
   input  wire        ref_clk;
   input  wire        rstn;
   input  wire        clk_en;
   input  wire        issue;
   input  wire [5:0]  op_sel;
   input  wire [7:0]  rd_val;
   input  wire [7:0]  rr_val;
   input  wire [15:0] pair_val;
   input  wire [7:0]  imm_val;
   input  wire [2:0]  mul_mode;
   input  wire [2:0]  bit_sel;
   input  wire        bit_pol;
   input  wire [7:0]  io_val;
   input  wire [15:0] z_ptr;
   input  wire [5:0]  seg_val;
   input  wire [7:0]  flags_in;
   input  wire [11:0] rel_off;
   input  wire        next_two_word;
   input  wire [21:0] pc_in;
   output wire        busy;
   output reg         done;
   output reg         res_we;
   output reg  [7:0]  res_data;
   output reg         pair_we;
   output reg  [15:0] pair_data;
   output reg         prod_we;
   output reg  [15:0] prod_data;
   output reg         flags_we;
   output reg  [7:0]  flags_out;
   output reg         pc_we;
   output reg  [21:0] pc_out;
   output reg         push_pc;
   output reg  [2:0]  cycles;

   localparam ST_IDLE = 2'b01;
   localparam ST_WAIT = 2'b10;

   reg  [1:0]  state_r;
   reg  [1:0]  state_nxt;
   reg  [2:0]  cnt_r;
   reg  [2:0]  cnt_nxt;
   wire [7:0]  alu_res;
   wire [7:0]  alu_flags;
   wire        alu_we;
   wire [15:0] mul_prod;
   wire        mul_c;
   wire        mul_z;
   reg         cond;
   reg  [2:0]  ncyc;
   reg  [16:0] wsum;
   reg  [7:0]  wflags;
   reg         wv;
   reg  [21:0] pc_calc;
   reg         pc_ld;
   reg         skip;

   // pc plus a signed 12-bit offset plus one
   function [21:0] rel_target;
      input [21:0] pc;
      input [11:0] off;
      begin
         rel_target = pc + {{10{off[11]}}, off} + 22'h000001;
      end
   endfunction

   // skip distance and cost by the size of the skipped word
   function [2:0] skip_cycles;
      input two_word;
      begin
         skip_cycles = two_word ? `AEX_CYC_THREE : `AEX_CYC_TWO;
      end
   endfunction

   aex_alu8 u_alu (
      .op_sel    (op_sel),
      .rd_val    (rd_val),
      .rr_val    ((op_sel == `AEX_OP_SBC || op_sel == `AEX_OP_SUB || op_sel == `AEX_OP_AND ||
                   op_sel == `AEX_OP_OR || op_sel == `AEX_OP_CMP || op_sel == `AEX_OP_SETM ||
                   op_sel == `AEX_OP_CLRM) ? imm_val : rr_val),
      .flags_in  (flags_in),
      .res_out   (alu_res),
      .flags_out (alu_flags),
      .wr_en     (alu_we)
   );

   aex_mul8 u_mul (
      .rd_val    (rd_val),
      .rr_val    (rr_val),
      .mul_mode  (mul_mode),
      .prod_out  (mul_prod),
      .carry_out (mul_c),
      .zero_out  (mul_z)
   );

   // decode: condition, pc target and cycle count
   always @* begin
      cond    = 1'b0;
      skip    = 1'b0;
      pc_ld   = 1'b0;
      pc_calc = pc_in + 22'h000001;
      ncyc    = `AEX_CYC_ONE;
      wsum    = 17'h00000;
      wv      = 1'b0;
      wflags  = flags_in;
      case (op_sel)
         `AEX_OP_WADD: begin
            wsum = {1'b0, pair_val} + {11'h000, imm_val[5:0]};
            wv = ~pair_val[15] & wsum[15];
            wflags[`AEX_F_C] = wsum[16];
            ncyc = `AEX_CYC_TWO;
         end
         `AEX_OP_WSUB: begin
            wsum = {1'b0, pair_val} - {11'h000, imm_val[5:0]};
            wv = pair_val[15] & ~wsum[15];
            wflags[`AEX_F_C] = wsum[16];
            ncyc = `AEX_CYC_TWO;
         end
         `AEX_OP_MUL: ncyc = `AEX_CYC_TWO;
         `AEX_OP_ZJMP, `AEX_OP_XJMP: begin
            pc_ld = 1'b1;
            pc_calc = (op_sel == `AEX_OP_XJMP) ? {seg_val, z_ptr} : {6'h00, z_ptr};
            ncyc = `AEX_CYC_TWO;
         end
         `AEX_OP_ZCALL: begin
            pc_ld = 1'b1;
            pc_calc = {6'h00, z_ptr};
            ncyc = WIDE_PC ? `AEX_CYC_FOUR : `AEX_CYC_THREE;
         end
         `AEX_OP_XCALL: begin
            pc_ld = 1'b1;
            pc_calc = {seg_val, z_ptr};
            ncyc = `AEX_CYC_FOUR;
         end
         `AEX_OP_CPSKIP, `AEX_OP_RBSKIP, `AEX_OP_IOSKIP: begin
            case (op_sel)
               `AEX_OP_CPSKIP: skip = (rd_val == rr_val);
               `AEX_OP_RBSKIP: skip = (rr_val[bit_sel] == bit_pol);
               default:        skip = (io_val[bit_sel] == bit_pol);
            endcase
            if (skip) begin
               pc_ld = 1'b1;
               pc_calc = pc_in + (next_two_word ? 22'h000003 : 22'h000002);
               ncyc = skip_cycles(next_two_word);
            end
         end
         `AEX_OP_BRANCH, `AEX_OP_BRSGE, `AEX_OP_BRSLT: begin
            case (op_sel)
               // flag branch also serves carry and interrupt tests
               `AEX_OP_BRANCH: cond = (flags_in[bit_sel] == bit_pol);
               `AEX_OP_BRSGE:  cond = ~(flags_in[`AEX_F_N] ^ flags_in[`AEX_F_V]);
               default:        cond = flags_in[`AEX_F_N] ^ flags_in[`AEX_F_V];
            endcase
            if (cond) begin
               pc_ld = 1'b1;
               pc_calc = rel_target(pc_in, rel_off);
               ncyc = `AEX_CYC_TWO;
            end
         end
         default: begin
            ncyc = `AEX_CYC_ONE;
         end
      endcase
      wflags[`AEX_F_Z] = (wsum[15:0] == 16'h0000);
      wflags[`AEX_F_N] = wsum[15];
      wflags[`AEX_F_V] = wv;
      wflags[`AEX_F_S] = wsum[15] ^ wv;
   end

   // sequencing: results appear in the cycle after issue, then the remaining cycles are waited out
   always @* begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         ST_IDLE: begin
            if (issue && ncyc != `AEX_CYC_ONE) begin
               state_nxt = ST_WAIT;
               cnt_nxt = ncyc - `AEX_CYC_ONE;
            end
         end
         ST_WAIT: begin
            cnt_nxt = cnt_r - `AEX_CYC_ONE;
            if (cnt_r == `AEX_CYC_ONE)
               state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
            cnt_nxt = 3'h0;
         end
      endcase
   end

   assign busy = (state_r == ST_WAIT) && (cnt_r != `AEX_CYC_ONE);

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_r   <= ST_IDLE;
         cnt_r     <= 3'h0;
         done      <= 1'b0;
         res_we    <= 1'b0;
         res_data  <= 8'h00;
         pair_we   <= 1'b0;
         pair_data <= 16'h0000;
         prod_we   <= 1'b0;
         prod_data <= 16'h0000;
         flags_we  <= 1'b0;
         flags_out <= 8'h00;
         pc_we     <= 1'b0;
         pc_out    <= `AEX_RESET_PC;
         push_pc   <= 1'b0;
         cycles    <= 3'h0;
      end else if (clk_en) begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         done    <= 1'b0;
         res_we  <= 1'b0;
         pair_we <= 1'b0;
         prod_we <= 1'b0;
         flags_we <= 1'b0;
         pc_we   <= 1'b0;
         push_pc <= 1'b0;
         if (issue && state_r == ST_IDLE) begin
            cycles  <= ncyc;
            done    <= 1'b1;
            pc_we   <= 1'b1;
            pc_out  <= pc_calc;
            push_pc <= (op_sel == `AEX_OP_ZCALL || op_sel == `AEX_OP_XCALL);
            case (op_sel)
               `AEX_OP_WADD, `AEX_OP_WSUB: begin
                  pair_we   <= 1'b1;
                  pair_data <= wsum[15:0];
                  flags_we  <= 1'b1;
                  flags_out <= wflags;
               end
               `AEX_OP_MUL: begin
                  prod_we   <= 1'b1;
                  prod_data <= mul_prod;
                  flags_we  <= 1'b1;
                  flags_out <= {flags_in[7:2], mul_z, mul_c};
               end
               default: begin
                  if (op_sel <= `AEX_OP_CMPC && op_sel != `AEX_OP_NOP) begin
                     res_we    <= alu_we;
                     res_data  <= alu_res;
                     flags_we  <= 1'b1;
                     flags_out <= alu_flags;
                  end
                  if (!pc_ld)
                     pc_out <= pc_in + 22'h000001;
               end
            endcase
         end
      end
   end
endmodule

// File: aex_exec_checker.sv
// assertion checker for the alu and branch execution block
`timescale 1ns/1ps
`include "aex_defines.vh"
module aex_exec_checker #(
   parameter WIDE_PC = 1'h1
) (
   input logic        ref_clk,
   input logic        rstn,
   input logic [5:0]  op_sel,
   input logic [7:0]  rd_val,
   input logic [7:0]  rr_val,
   input logic [7:0]  imm_val,
   input logic [2:0]  mul_mode,
   input logic [2:0]  bit_sel,
   input logic        bit_pol,
   input logic [15:0] z_ptr,
   input logic [5:0]  seg_val,
   input logic [7:0]  flags_in,
   input logic [11:0] rel_off,
   input logic        next_two_word,
   input logic [21:0] pc_in,
   input logic        done,
   input logic        res_we,
   input logic [7:0]  res_data,
   input logic        pair_we,
   input logic [15:0] pair_data,
   input logic        prod_we,
   input logic [15:0] prod_data,
   input logic        flags_we,
   input logic [7:0]  flags_out,
   input logic [21:0] pc_out,
   input logic        push_pc,
   input logic [2:0]  cycles
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   AST_SBC_RESULT:
      assert property (done && $past(op_sel) == `AEX_OP_SBC
         |-> res_we && cycles == 3'h1 && res_data == $past(rd_val - imm_val - flags_in[0]))
      else $error("subtract with carry result wrong");
   AST_WORD_FLAGS:
      assert property (pair_we |-> cycles == 3'h2 && flags_out[1] == (pair_data == 16'h0000)
         && flags_out[4] == (flags_out[2] ^ flags_out[3]) && flags_out[5] == $past(flags_in[5]))
      else $error("word operation flags wrong");
   AST_LOGIC_KEEP:
      assert property (done && $past(op_sel) inside {`AEX_OP_AND, `AEX_OP_OR, `AEX_OP_EOR}
         |-> flags_out[0] == $past(flags_in[0]) && flags_out[5] == $past(flags_in[5])
         && flags_out[1] == (res_data == 8'h00))
      else $error("logic operation flags wrong");
   AST_MUL_TWO:
      assert property (prod_we |-> cycles == 3'h2 && flags_out[1] == (prod_data == 16'h0000) ##1 !done)
      else $error("multiply timing or zero flag wrong");
   AST_FRAC_SHIFT:
      assert property (prod_we && $past(mul_mode[2]) |-> !prod_data[0])
      else $error("fractional product not shifted");
   AST_ZJMP_PC:
      assert property (done && $past(op_sel) == `AEX_OP_ZJMP
         |-> pc_out == {6'h00, $past(z_ptr)} && !flags_we && cycles == 3'h2)
      else $error("indirect jump target wrong");
   AST_ZCALL_LEN:
      assert property (done && $past(op_sel) == `AEX_OP_ZCALL
         |-> push_pc && pc_out[21:16] == 6'h00 && cycles == (WIDE_PC ? 3'h4 : 3'h3))
      else $error("indirect call wrong");
   AST_XCALL_GAP:
      assert property (done && $past(op_sel) == `AEX_OP_XCALL
         |-> pc_out == {$past(seg_val), $past(z_ptr)} && push_pc ##1 !done [*3])
      else $error("extended call wrong");
   AST_SKIP_EQ:
      assert property (done && $past(op_sel) == `AEX_OP_CPSKIP && $past(rd_val == rr_val)
         |-> !flags_we && cycles == ($past(next_two_word) ? 3'h3 : 3'h2)
         && pc_out == $past(pc_in) + {19'h00000, cycles})
      else $error("compare skip wrong");
   AST_BRANCH_TAKEN:
      assert property (done && $past(op_sel) == `AEX_OP_BRANCH && $past(flags_in[bit_sel] == bit_pol)
         |-> cycles == 3'h2 && pc_out == $past(pc_in + {{10{rel_off[11]}}, rel_off} + 22'h000001))
      else $error("taken branch wrong");
   AST_SIGNED_GE:
      assert property (done && $past(op_sel) == `AEX_OP_BRSGE
         |-> cycles == ($past(flags_in[2] ^ flags_in[3]) ? 3'h1 : 3'h2))
      else $error("signed branch decision wrong");
   AST_CMP_NOWR:
      assert property (done && $past(op_sel) inside {`AEX_OP_CMP, `AEX_OP_CMPC} |-> !res_we && flags_we)
      else $error("compare wrote a register");
   cover property (prod_we && $past(mul_mode[2]));
   cover property (push_pc);
   cover property (done && cycles == 3'h3);
endmodule

// File: alu_and_branch_execution_tb.sv
// self-checking bench for the alu and branch execution block
`timescale 1ns/1ps
`include "aex_defines.vh"
module alu_and_branch_execution_tb;
   typedef struct packed {
      logic [5:0]  we;
      logic [5:0]  wm;
      logic [2:0]  cyc;
      logic [1:0]  kd;
      logic [15:0] d;
      logic        fc;
      logic [7:0]  f;
      logic        pcc;
      logic [21:0] pc;
   } aex_exp_t;
   logic        ref_clk, rstn, clk_en, issue, bit_pol, next_two_word, hit, tw, pol;
   logic        done, res_we, pair_we, prod_we, flags_we, pc_we, push_pc, busy;
   logic [5:0]  op_sel, seg_val;
   logic [7:0]  rd_val, rr_val, imm_val, io_val, flags_in, a, b, fl, r, f, res_data, flags_out;
   logic [15:0] pair_val, z_ptr, w, sv, pair_data, prod_data;
   logic [2:0]  mul_mode, bit_sel, s, cy, cycles;
   logic [11:0] rel_off;
   logic [21:0] pc_in, pc, pc_out;
   aex_exp_t    q[$];
   aex_exp_t    me;
   int          errors, cmp_count, i, j;
   logic [5:0]  lop [6] = '{`AEX_OP_AND, `AEX_OP_OR, `AEX_OP_EOR, `AEX_OP_SETM, `AEX_OP_CLRM, `AEX_OP_TEST};
   logic [2:0]  mmd [6] = '{3'h0, 3'h3, 3'h1, 3'h4, 3'h7, 3'h5};
   aex_exec dut_u (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .issue(issue), .op_sel(op_sel),
      .rd_val(rd_val), .rr_val(rr_val), .pair_val(pair_val), .imm_val(imm_val), .mul_mode(mul_mode),
      .bit_sel(bit_sel), .bit_pol(bit_pol), .io_val(io_val), .z_ptr(z_ptr), .seg_val(seg_val),
      .flags_in(flags_in), .rel_off(rel_off), .next_two_word(next_two_word), .pc_in(pc_in), .busy(busy),
      .done(done), .res_we(res_we), .res_data(res_data), .pair_we(pair_we), .pair_data(pair_data),
      .prod_we(prod_we), .prod_data(prod_data), .flags_we(flags_we), .flags_out(flags_out), .pc_we(pc_we),
      .pc_out(pc_out), .push_pc(push_pc), .cycles(cycles));
   always #5 ref_clk = ~ref_clk;
   // difference and flags (c z n v s h from bit 0) of x - y - ci
   function automatic logic [15:0] sub8(input logic [7:0] x, y, fi, input logic ci, ch);
      logic [7:0] d, g;
      d = x - y - ci;
      g = fi;
      g[0] = (~x[7] & y[7]) | (y[7] & d[7]) | (d[7] & ~x[7]);
      g[5] = (~x[3] & y[3]) | (y[3] & d[3]) | (d[3] & ~x[3]);
      g[3] = (x[7] & ~y[7] & ~d[7]) | (~x[7] & y[7] & d[7]);
      g[2] = d[7];
      g[4] = d[7] ^ g[3];
      g[1] = (d == 8'h00) & (~ch | fi[1]);
      return {g, d};
   endfunction
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      cmp_count++;
      if (got !== ex) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // issue held through the wait, so refused issues are exercised too
   task automatic go(input logic [5:0] op, input aex_exp_t e);
      op_sel <= op;
      issue <= 1'h1;
      q.push_back(e);
      @(posedge ref_clk);
      repeat (e.cyc - 3'h1) @(posedge ref_clk);
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      if (rstn && done === 1'h1) begin
         if (q.size() == 0) chk("spare done", 32'h0, 32'h1);
         else begin
            me = q.pop_front();
            chk("we", me.we & me.wm, {res_we, pair_we, prod_we, flags_we, pc_we, push_pc} & me.wm);
            chk("cycles", me.cyc, cycles);
            chk("pc_we busy", {1'h1, me.cyc > 3'h2}, {pc_we, busy});
            if (me.kd != 2'h0) chk("data", me.d, me.kd == 2'h1 ? {8'h00, res_data} :
               me.kd == 2'h2 ? pair_data : prod_data);
            if (me.fc) chk("flags", me.f, flags_out);
            if (me.pcc) chk("pc", me.pc, pc_out);
         end
      end
   end
   initial begin
      {ref_clk, rstn, issue, bit_pol, next_two_word, op_sel, seg_val} = '0;
      {rd_val, rr_val, imm_val, io_val, flags_in, pair_val, z_ptr, mul_mode, bit_sel, rel_off, pc_in} = '0;
      clk_en = 1'h1;
      errors = 0;
      cmp_count = 0;
      void'($urandom(32'h946c));
      repeat (8) @(posedge ref_clk);
      rstn <= 1'h1;
      @(posedge ref_clk);
      clk_en <= 1'h0;
      issue <= 1'h1;
      repeat (3) @(posedge ref_clk);
      clk_en <= 1'h1;
      for (i = 0; i < 8; i++) begin
         {a, b, fl, w} = {$urandom, $urandom};
         {pc, tw, hit, s} = $urandom;
         cy = mmd[i % 6];
         rd_val <= a;
         rr_val <= b;
         imm_val <= b;
         flags_in <= fl;
         pair_val <= w;
         z_ptr <= w;
         seg_val <= b[5:0];
         pc_in <= pc;
         rel_off <= {a[3:0], b};
         next_two_word <= tw;
         mul_mode <= cy;
         io_val <= a;
         {f, r} = sub8(a, b, fl, fl[0], 1'h1);
         go(`AEX_OP_SBC, '{6'h24, 6'h24, 3'h1, 2'h1, {8'h00, r}, 1'h1, f, 1'h0, 22'h0});
         {f, r} = sub8(a, b, fl, 1'h0, 1'h0);
         go(`AEX_OP_CMP, '{6'h04, 6'h24, 3'h1, 2'h0, 16'h0, 1'h1, f, 1'h0, 22'h0});
         {f, r} = sub8(a, b, fl, fl[0], 1'h1);
         go(`AEX_OP_CMPC, '{6'h04, 6'h24, 3'h1, 2'h0, 16'h0, 1'h1, f, 1'h0, 22'h0});
         for (j = 0; j < 6; j++) begin
            case (j)
               0: r = a & b;
               1, 3: r = a | b;
               2: r = a ^ b;
               4: r = a & ~b;
               default: r = a;
            endcase
            f = fl;
            f[1] = (r == 8'h00);
            f[2] = r[7];
            f[3] = 1'h0;
            f[4] = r[7];
            go(lop[j], '{6'h24, 6'h24, 3'h1, 2'h1, {8'h00, r}, 1'h1, f,
               1'h0, 22'h0});
         end
         for (j = 0; j < 2; j++) begin
            sv = j ? w - b[5:0] : w + b[5:0];
            f = fl;
            f[2] = sv[15];
            f[1] = (sv == 16'h0000);
            f[0] = j ? sv[15] & ~w[15] : ~sv[15] & w[15];
            f[3] = j ? w[15] & ~sv[15] : ~w[15] & sv[15];
            f[4] = f[2] ^ f[3];
            go(`AEX_OP_WADD + j[5:0], '{6'h14, 6'h14, 3'h2, 2'h2, sv, 1'h1, f, 1'h0, 22'h0});
         end
         sv = (cy[0] ? {{8{a[7]}}, a} : {8'h00, a}) * (cy[1] ? {{8{b[7]}}, b} : {8'h00, b});
         f = fl;
         f[0] = sv[15];
         if (cy[2]) sv = sv << 1;
         f[1] = (sv == 16'h0000);
         go(`AEX_OP_MUL, '{6'h0c, 6'h0c, 3'h2, 2'h3, sv, 1'h1, f, 1'h0, 22'h0});
         for (j = 0; j < 4; j++)
            go(`AEX_OP_ZJMP + j[5:0], '{{5'h00, j[1]}, 6'h05, j[1] ? 3'h4 : 3'h2, 2'h0, 16'h0, 1'h0, 8'h00,
               1'h1, {j[0] ? b[5:0] : 6'h00, w}});
         bit_sel <= s;
         for (j = 0; j < 3; j++) begin
            rr_val <= (j == 0 && !hit) ? ~a : a;
            bit_pol <= hit ? a[s] : ~a[s];
            cy = hit ? (tw ? 3'h3 : 3'h2) : 3'h1;
            go(`AEX_OP_CPSKIP + j[5:0], '{6'h00, 6'h05, cy, 2'h0, 16'h0, 1'h0, 8'h00, 1'h1,
               pc + cy});
         end
         for (j = 0; j < 10; j++) begin
            pol = $urandom;
            bit_sel <= j[2:0];
            bit_pol <= pol;
            hit = j < 8 ? fl[j[2:0]] == pol : (fl[2] ^ fl[3]) == (j == 9);
            cy = hit ? 3'h2 : 3'h1;
            go(j < 8 ? `AEX_OP_BRANCH : `AEX_OP_BRSGE + j[5:0] - 6'h08, '{6'h00, 6'h05, cy, 2'h0, 16'h0, 1'h0, 8'h00,
               1'h1, hit ? pc + {{10{a[3]}}, a[3:0], b} + 22'h1 : pc + 22'h1});
         end
         $display("round %0d complete", i);
      end
      issue <= 1'h0;
      for (j = 0; j < 20 && q.size() != 0; j++) @(posedge ref_clk);
      if (q.size() != 0) chk("drain", 32'h0, q.size());
      conclude();
   end
endmodule
bind aex_exec aex_exec_checker #(.WIDE_PC(WIDE_PC)) chk_u (.ref_clk(ref_clk), .rstn(rstn), .op_sel(op_sel),
   .rd_val(rd_val), .rr_val(rr_val), .imm_val(imm_val), .mul_mode(mul_mode), .bit_sel(bit_sel),
   .bit_pol(bit_pol), .z_ptr(z_ptr), .seg_val(seg_val), .flags_in(flags_in), .rel_off(rel_off),
   .next_two_word(next_two_word), .pc_in(pc_in), .done(done), .res_we(res_we), .res_data(res_data),
   .pair_we(pair_we), .pair_data(pair_data), .prod_we(prod_we), .prod_data(prod_data), .flags_we(flags_we),
   .flags_out(flags_out), .pc_out(pc_out), .push_pc(push_pc), .cycles(cycles));
